// ==== verilog/test_signal_mode_generator.sv ====
// Test signal generator: sine, dc, bitstream and pulse sources with gain
//
// What this block does
// - A two-bit mode selects sine (00), dc (01), external bitstream (10) or pulse (11).
// - Sine frequency is 250 Hz over two to the octave bit, times (numerator+1)/(denominator+1), while that product is at most 250 Hz.
// - Every sine frequency is derived from clk_sys by TICK_STEP, fixed for the nominal 4.096 MHz master clock / 16.
// - A write to the numerator or denominator restarts the sine at its zero crossing.
// - In sine mode, driving phase-align high resets the sine phase to the zero crossing.
// - The three-bit analog gain attenuates in 6 dB steps, 000 is 0 dB and 110 is -36 dB.
// - Sine attenuation is 0.5 dB per code to -119.5 dB, and upper nibble 1111 mutes.
// - Sine amplitude in dB is the analog gain plus the digital attenuation.
// - In dc mode the output is the 24-bit level scaled by the analog gain.
// - The dc level is two's complement with zero giving zero output.
// - In power-down both differential output pins are released to high impedance.
// - In pulse mode pulse level A is output while phase-align is low, B while high.
// - Sine or dc level feeds a modulator making the ones-density stream for the converter.
`timescale 1ns/1ps
module test_signal_mode_generator import tsg_pkg::*; #(
  parameter logic [31:0] TICK_STEP = TICK_INC
) (
  input wire logic clk_sys,  // System clock, 200 MHz
  input wire logic rst_n,  // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input wire logic s_axi_awvalid,  // Write address valid
  output logic s_axi_awready,  // Write address ready
  input wire logic [31:0] s_axi_wdata,  // Write data
  input wire logic [3:0] s_axi_wstrb,  // Write byte enables
  input wire logic s_axi_wvalid,  // Write data valid
  output logic s_axi_wready,  // Write data ready
  output logic [1:0] s_axi_bresp,  // Write response
  output logic s_axi_bvalid,  // Write response valid
  input wire logic s_axi_bready,  // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
  input wire logic s_axi_arvalid,  // Read address valid
  output logic s_axi_arready,  // Read address ready
  output logic [31:0] s_axi_rdata,  // Read data
  output logic [1:0] s_axi_rresp,  // Read response
  output logic s_axi_rvalid,  // Read data valid
  input wire logic s_axi_rready,  // Read data ready
  input wire logic phase_align,  // Phase align / pulse select input
  input wire logic switch_or_bitstream_pin,  // External bitstream input
  input wire logic power_down_n,  // Power-down, active low
  output logic positive_output,  // Positive output bit
  output logic positive_output_oe,  // Positive output enable
  output logic negative_output,  // Negative output bit
  output logic negative_output_oe,  // Negative output enable
  output logic [4:0] pulse_level  // Code for the pulse converter
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (TICK_STEP == 32'h0000_0000) begin : g_bad_tick
    $error("TICK_STEP must be nonzero");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus state
  logic [1:0] mode_ff;
  logic [2:0] gain_ff;
  logic [3:0] numer_ff;
  logic octave_ff;
  logic [7:0] denom_ff;
  logic [7:0] atten_ff;
  logic [23:0] dc_ff;
  logic [4:0] pulse_a_ff;
  logic [4:0] pulse_b_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic restart;
  logic [9:0] phase_ff;
  logic out_bit_ff;
  logic align_prev_ff;

  // Byte-enable merge of a stored word with new write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // One write at a time: both halves must be latched before the commit
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign do_write = aw_hold_ff && w_hold_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Address and data channels latched independently
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  // Write response, error for an unmapped or read-only offset
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      if (awaddr_ff == OFS_GAIN_SRC || awaddr_ff == OFS_OCTAVE_HALVING_BIT || awaddr_ff == OFS_DENOM ||
          awaddr_ff == OFS_ATTEN || awaddr_ff == OFS_DC_LEVEL || awaddr_ff == OFS_PULSE) begin
        bresp_ff <= RESP_OKAY;
      end else begin
        bresp_ff <= RESP_SLVERR;
      end
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Register file update
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_ff <= MODE_SINE;
      gain_ff <= GAIN_RST;
      numer_ff <= NUMER_RST;
      octave_ff <= 1'b0;
      denom_ff <= DENOM_RST;
      atten_ff <= ATTEN_RST;
      dc_ff <= DC_RST;
      pulse_a_ff <= PULSE_RST;
      pulse_b_ff <= PULSE_RST;
    end else if (do_write) begin
      if (awaddr_ff == OFS_GAIN_SRC) begin
        mode_ff <= wstrb_ff[0] ? wdata_ff[MODE_LSB +: 2] : mode_ff;
        gain_ff <= wstrb_ff[0] ? wdata_ff[GAIN_LSB +: 3] : gain_ff;
      end else if (awaddr_ff == OFS_OCTAVE_HALVING_BIT) begin
        numer_ff <= wstrb_ff[0] ? wdata_ff[NUMER_LSB +: 4] : numer_ff;
        octave_ff <= wstrb_ff[1] ? wdata_ff[OCT_BIT] : octave_ff;
      end else if (awaddr_ff == OFS_DENOM) begin
        denom_ff <= wstrb_ff[0] ? wdata_ff[7:0] : denom_ff;
      end else if (awaddr_ff == OFS_ATTEN) begin
        atten_ff <= wstrb_ff[0] ? wdata_ff[7:0] : atten_ff;
      end else if (awaddr_ff == OFS_DC_LEVEL) begin
        dc_ff <= 24'(merge({8'h00, dc_ff}, wdata_ff, wstrb_ff));
      end else if (awaddr_ff == OFS_PULSE) begin
        pulse_a_ff <= wstrb_ff[0] ? wdata_ff[PULSE_A_LSB +: 5] : pulse_a_ff;
        pulse_b_ff <= wstrb_ff[1] ? wdata_ff[PULSE_B_LSB +: 5] : pulse_b_ff;
      end
    end
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      if (s_axi_araddr == OFS_GAIN_SRC) begin
        rdata_ff <= 32'({mode_ff, 1'b0, gain_ff});
      end else if (s_axi_araddr == OFS_OCTAVE_HALVING_BIT) begin
        rdata_ff <= 32'({octave_ff, 4'h0, numer_ff});
      end else if (s_axi_araddr == OFS_DENOM) begin
        rdata_ff <= 32'(denom_ff);
      end else if (s_axi_araddr == OFS_ATTEN) begin
        rdata_ff <= 32'(atten_ff);
      end else if (s_axi_araddr == OFS_DC_LEVEL) begin
        rdata_ff <= 32'(dc_ff);
      end else if (s_axi_araddr == OFS_PULSE) begin
        rdata_ff <= 32'({pulse_b_ff, 3'h0, pulse_a_ff});
      end else if (s_axi_araddr == OFS_STATUS) begin
        rdata_ff[STAT_MODE_LSB +: 2] <= mode_ff;
        rdata_ff[STAT_BIT_POS] <= out_bit_ff;
        rdata_ff[STAT_ALIGN_POS] <= phase_align;
        rdata_ff[STAT_PHASE_LSB +: 10] <= phase_ff;
      end else begin
        rresp_ff <= RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample tick at master clock / 16
  logic [31:0] tick_acc_ff;
  logic tick_ff;
  logic [32:0] tick_sum;

  assign tick_sum = {1'b0, tick_acc_ff} + {1'b0, TICK_STEP};

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_acc_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      tick_acc_ff <= tick_sum[31:0];
      tick_ff <= tick_sum[32];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sine phase: 1024 phase steps per cycle, 256000 / 1024 = 250 Hz maximum
  logic [10:0] frac_ff;
  logic [10:0] frac_sum;
  logic [10:0] frac_lim;
  logic align_rise;

  assign restart = do_write && (awaddr_ff == OFS_OCTAVE_HALVING_BIT || awaddr_ff == OFS_DENOM);
  assign align_rise = phase_align && !align_prev_ff && mode_ff == MODE_SINE;
  assign frac_lim = ({3'h0, denom_ff} + 11'h001) << octave_ff;
  assign frac_sum = frac_ff + {7'h00, numer_ff} + 11'h001;

  // Ratio kept as a remainder so no drift builds up; numerator above
  // denominator still gives only one phase step per tick while the remainder keeps growing
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      frac_ff <= 11'h000;
      phase_ff <= 10'h000;
      align_prev_ff <= 1'b0;
    end else begin
      align_prev_ff <= phase_align;
      if (restart || align_rise || !power_down_n) begin
        frac_ff <= 11'h000;
        phase_ff <= 10'h000;
      end else if (tick_ff) begin
        // relies on numer not above denom
        if (frac_sum >= frac_lim) begin
          frac_ff <= frac_sum - frac_lim;
          phase_ff <= phase_ff + 10'h001;
        end else begin
          frac_ff <= frac_sum;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sine shape: parabolic half-waves, zero crossing at phase zero
  logic [8:0] half_pos;
  logic [17:0] para;
  logic [23:0] sine_mag;
  logic signed [23:0] sine_raw;

  assign half_pos = phase_ff[8:0];
  assign para = 18'(half_pos) * 18'(10'h200 - {1'b0, half_pos});
  assign sine_mag = para[16] ? SINE_PEAK : {para[15:0], 8'h00} >> 1;
  assign sine_raw = phase_ff[9] ? -$signed(sine_mag) : $signed(sine_mag);

  ////////////////////////////////////////////////////////////////////////////
  // Gain path: analog halvings and 0.5 dB digital steps
  logic [2:0] gain_eff;
  logic [4:0] dig_shift;
  logic [3:0] dig_idx;
  logic signed [40:0] atten_prod;
  logic signed [23:0] sine_att;
  logic [5:0] sine_shift;
  logic mute;
  logic signed [23:0] level_ff;

  assign gain_eff = (gain_ff > GAIN_MAX) ? GAIN_MAX : gain_ff;
  assign mute = atten_ff[7:4] == MUTE_NIBBLE;
  assign dig_shift = 5'(atten_ff / STEPS_PER_6DB);
  assign dig_idx = 4'(atten_ff % STEPS_PER_6DB);
  assign atten_prod = sine_raw * $signed({1'b0, atten_mant(dig_idx)});
  assign sine_att = atten_prod[39:16];
  assign sine_shift = {1'b0, dig_shift} + {3'h0, gain_eff};

  // Modulator input; registered once, so both multiplies and the shift share one cycle
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      level_ff <= 24'h00_0000;
    end else begin
      case (mode_ff)
        MODE_SINE: begin
          // 6 dB analog steps
          // Signed zero keeps the shift arithmetic for negative half-waves
          level_ff <= mute ? 24'sh00_0000 : sine_att >>> sine_shift;
        end
        MODE_DC: begin
          level_ff <= $signed(dc_ff) >>> gain_eff;
        end
        default: begin
          level_ff <= 24'h00_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator and output stage
  logic mod_bit;

  ones_density_modulator #(
    .WIDTH(24)
  ) u_mod (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .step(tick_ff),
    .level(level_ff),
    .bit_out(mod_bit)
  );

  // External stream sampled on the same tick; no gain can be applied to it
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_bit_ff <= 1'b0;
    end else if (mode_ff == MODE_BITSTREAM) begin
      out_bit_ff <= tick_ff ? switch_or_bitstream_pin : out_bit_ff;
    end else begin
      out_bit_ff <= mod_bit;
    end
  end

  // Pulse converter code, follows phase align directly
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pulse_level <= PULSE_RST;
    end else if (mode_ff == MODE_PULSE) begin
      // A when low, B when high
      pulse_level <= phase_align ? pulse_b_ff : pulse_a_ff;
    end else begin
      pulse_level <= PULSE_RST;
    end
  end

  // Complementary pins, released while powered down
  assign positive_output = out_bit_ff;
  assign negative_output = !out_bit_ff;
  assign positive_output_oe = power_down_n && rst_sync_n;
  assign negative_output_oe = power_down_n && rst_sync_n;

endmodule  // test_signal_mode_generator

// ==== verilog/tsg_pkg.sv ====
// Constants, register map and mode codes for the test signal generator
package tsg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking
  localparam int unsigned CLK_HZ = 200_000_000;  // clk_sys, 5 ns period
  localparam int unsigned MCLK_REF_HZ = 4_096_000;  // Nominal master clock
  localparam int unsigned SAMPLE_DIV = 16;  // Sample tick is master clock / 16
  // Fractional increment: carry out of a 32-bit accumulator gives the tick
  localparam logic [31:0] TICK_INC =
    32'((64'(MCLK_REF_HZ / SAMPLE_DIV) << 32) / 64'(CLK_HZ));

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_GAIN_SRC = 8'h00;
  localparam logic [7:0] OFS_OCTAVE_HALVING_BIT = 8'h04;
  localparam logic [7:0] OFS_DENOM = 8'h08;
  localparam logic [7:0] OFS_ATTEN = 8'h0C;
  localparam logic [7:0] OFS_DC_LEVEL = 8'h10;
  localparam logic [7:0] OFS_PULSE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Field positions
  localparam int unsigned GAIN_LSB = 0;
  localparam int unsigned MODE_LSB = 4;
  localparam int unsigned NUMER_LSB = 0;
  localparam int unsigned OCT_BIT = 8;
  localparam int unsigned PULSE_A_LSB = 0;
  localparam int unsigned PULSE_B_LSB = 8;
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_BIT_POS = 4;
  localparam int unsigned STAT_ALIGN_POS = 5;
  localparam int unsigned STAT_PHASE_LSB = 16;

  // Reset values
  localparam logic [2:0] GAIN_RST = 3'h0;
  localparam logic [3:0] NUMER_RST = 4'h0;
  localparam logic [7:0] DENOM_RST = 8'h00;
  localparam logic [7:0] ATTEN_RST = 8'h00;
  localparam logic [23:0] DC_RST = 24'h00_0000;
  localparam logic [4:0] PULSE_RST = 5'h00;

  // Gain and attenuation coding
  localparam logic [2:0] GAIN_MAX = 3'h6;  // Deepest valid analog step
  localparam logic [3:0] MUTE_NIBBLE = 4'hF;
  localparam logic [7:0] STEPS_PER_6DB = 8'h0C;  // 0.5 dB steps in one halving
  localparam logic [23:0] SINE_PEAK = 24'h7F_FFFF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_SINE = 2'b00,
    MODE_DC = 2'b01,
    MODE_BITSTREAM = 2'b10,
    MODE_PULSE = 2'b11
  } mode_e;

  // Mantissa of 10^(-i/40) in 16 bits, i = 0..11
  function automatic logic [15:0] atten_mant(input logic [3:0] i);
    case (i)
      4'h0: atten_mant = 16'hFFFF;
      4'h1: atten_mant = 16'hF1AD;
      4'h2: atten_mant = 16'hE429;
      4'h3: atten_mant = 16'hD765;
      4'h4: atten_mant = 16'hCB59;
      4'h5: atten_mant = 16'hBFF9;
      4'h6: atten_mant = 16'hB53C;
      4'h7: atten_mant = 16'hAB18;
      4'h8: atten_mant = 16'hA186;
      4'h9: atten_mant = 16'h987D;
      4'hA: atten_mant = 16'h8FF5;
      default: atten_mant = 16'h87E7;
    endcase
  endfunction

endpackage

// ==== verilog/ones_density_modulator.sv ====
// First-order modulator turning a signed level into a ones-density bitstream
`timescale 1ns/1ps
module ones_density_modulator import tsg_pkg::*; #(
  parameter int unsigned WIDTH = 24
) (
  input wire logic clk_sys,  // System clock
  input wire logic rst_sync_n,  // Synchronised reset, active low
  input wire logic step,  // One modulator update per pulse
  input wire logic signed [WIDTH-1:0] level,  // Signed input level
  output logic bit_out  // Ones-density bit
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (WIDTH < 8) begin : g_bad_width
    $error("ones_density_modulator WIDTH must be at least 8");
  end

  logic [WIDTH-1:0] acc_ff;
  logic [WIDTH-1:0] offset;
  logic [WIDTH:0] sum;

  // Full scale maps to 25..75 percent density, zero to half density
  assign offset = {1'b1, {(WIDTH-1){1'b0}}} + WIDTH'(level >>> 1);
  assign sum = {1'b0, acc_ff} + {1'b0, offset};

  // Carry out is the output bit; remainder is kept as the error term
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      acc_ff <= '0;
      bit_out <= 1'b0;
    end else if (step) begin
      acc_ff <= sum[WIDTH-1:0];
      bit_out <= sum[WIDTH];
    end
  end

endmodule  // ones_density_modulator

// ==== dv/tsg_chk.sv ====
// Port assertions for the test signal generator
`timescale 1ns/1ps
module tsg_chk (
  input wire logic clk_sys,  // Clock
  input wire logic rst_n,  // Reset, active low
  input wire logic s_axi_awready,  // Aw ready
  input wire logic s_axi_awvalid,  // Aw valid
  input wire logic s_axi_wready,  // W ready
  input wire logic s_axi_wvalid,  // W valid
  input wire logic s_axi_bvalid,  // B valid
  input wire logic s_axi_bready,  // B ready
  input wire logic [1:0] s_axi_bresp,  // B response
  input wire logic s_axi_arvalid,  // Ar valid
  input wire logic s_axi_arready,  // Ar ready
  input wire logic s_axi_rvalid,  // R valid
  input wire logic power_down_n,  // Power-down, active low
  input wire logic positive_output,  // Output bit
  input wire logic positive_output_oe,  // Output enable
  input wire logic negative_output,  // Inverse bit
  input wire logic negative_output_oe,  // Inverse enable
  input wire logic [4:0] pulse_level  // Pulse code
);
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Output pins and the bus handshakes
  a_pd_release: assert property (!power_down_n ##1 !power_down_n |-> !positive_output_oe)
    else $error("output driven in power-down");
  a_oe_pair: assert property (positive_output_oe == negative_output_oe)
    else $error("output enables differ");
  a_diff_inverse: assert property (positive_output_oe |-> negative_output != positive_output)
    else $error("outputs not complementary");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write answer late");
  c_pd: cover property (!positive_output_oe ##1 positive_output_oe);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_pulse: cover property (pulse_level != 5'h00 ##1 $changed(pulse_level));
endmodule  // tsg_chk

// ==== dv/adc_probe.sv ====
// Far-side model: ones-density meter and bitstream source
`timescale 1ns/1ps
module adc_probe (
  input wire logic clk_sys,  // Clock
  input wire logic positive_output,  // Output bit
  input wire logic positive_output_oe,  // Output enable
  input wire logic ones_clr,  // Restart the count
  output logic [15:0] ones_cnt,  // Ones since restart
  output logic switch_or_bitstream_pin  // Stream to the device
);
  ////////////////////////////////////////
  logic [2:0] pat_ff = 3'h0;
  // sixty percent stream
  // Period five so the 4-clock tick never locks onto one phase
  always_ff @(posedge clk_sys) begin
    pat_ff <= (pat_ff == 3'h4) ? 3'h0 : pat_ff + 3'h1;
  end
  assign switch_or_bitstream_pin = pat_ff < 3'h3;
  // Undriven output counts as zero
  always_ff @(posedge clk_sys) begin
    if (ones_clr) ones_cnt <= 16'h0000;
    else ones_cnt <= ones_cnt + 16'(positive_output_oe === 1'h1 && positive_output === 1'h1);
  end
endmodule  // adc_probe

// ==== dv/test_signal_mode_generator_tb.sv ====
// Self-checking bench for the test signal generator
`timescale 1ns/1ps
module test_signal_mode_generator_tb import tsg_pkg::*;;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, rd, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, phase_align = 1'h0, power_down_n = 1'h1, ones_clr = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic switch_or_bitstream_pin, positive_output, positive_output_oe;
  logic negative_output, negative_output_oe;
  logic [4:0] pulse_level;
  logic [15:0] ones_cnt;
  logic [9:0] p0;
  int n_errors = 0, total_checks = 0;
  logic [31:0] pf [4] = '{32'h0000_0000, 32'h0000_0100, 32'h0000_0001, 32'h0000_0000};
  logic [31:0] pd [4] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_0003, 32'h0000_0000};
  int ps [4] = '{100, 50, 200, 400};
  logic [31:0] dg [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h3, 32'h7};
  logic [23:0] dl [7] = '{24'h00_0000, 24'h7F_FFFF, 24'h80_0001, 24'hC0_0000, 24'h7F_FFFF,
    24'h7F_FFFF, 24'h7F_FFFF};
  int de [7] = '{2048, 3072, 1024, 1536, 2560, 2176, 2064};
  ////////////////////////////////////////
  always #2.5 clk_sys = ~clk_sys;
  // Fast tick: one sample every 4 clocks
  test_signal_mode_generator #(.TICK_STEP(32'h4000_0000)) test_signal_mode_generator_i (
    .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .phase_align, .switch_or_bitstream_pin, .power_down_n,
    .positive_output, .positive_output_oe, .negative_output, .negative_output_oe, .pulse_level);
  adc_probe adc_probe_i (.clk_sys, .positive_output, .positive_output_oe, .ones_clr, .ones_cnt,
    .switch_or_bitstream_pin);
  // Comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic near(input logic [31:0] seen, input int exp, input int tol);
    chk((seen + tol >= exp && seen <= exp + tol) ? 32'(exp) : seen, 32'(exp));
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Bus master: bready raised late so a pending response is seen to stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    r = 2'h3;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (s_axi_bready && s_axi_bvalid === 1'h1) begin
        r = s_axi_bresp;
        break;
      end
      s_axi_awvalid <= s_axi_awvalid && s_axi_awready !== 1'h1;
      s_axi_wvalid <= s_axi_wvalid && s_axi_wready !== 1'h1;
      s_axi_bready <= s_axi_bvalid === 1'h1;
    end
    s_axi_bready <= 1'h0;
    chk(32'(r), 32'(er));
  endtask
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    r = 2'h3;
    rd = 32'hFFFF_FFFF;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      s_axi_arvalid <= s_axi_arvalid && s_axi_arready !== 1'h1;
      if (s_axi_rvalid === 1'h1) begin
        rd = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'h0;
    chk(32'(r), 32'(er));
  endtask
  // Ones counted over 1024 ticks; settle first so the last setting governs
  task automatic dens(input int exp);
    repeat (200) @(posedge clk_sys);
    ones_clr <= 1'h1;
    @(posedge clk_sys);
    ones_clr <= 1'h0;
    repeat (4096) @(posedge clk_sys);
    near(32'(ones_cnt), exp, 32);
  endtask
  initial begin
    #400_000;
    n_errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rdr(OFS_DC_LEVEL, RESP_OKAY);
    chk(rd, 32'(DC_RST));
    wr(OFS_PULSE, 32'hFFFF_FFFF, RESP_OKAY);
    rdr(OFS_PULSE, RESP_OKAY);
    chk(rd, 32'h0000_1F1F);
    rdr(8'h1C, RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_0000, RESP_SLVERR);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_GAIN_SRC, 32'(m) << MODE_LSB, RESP_OKAY);
      rdr(OFS_STATUS, RESP_OKAY);
      chk(32'(rd[1:0]), 32'(m));
    end
    wr(OFS_PULSE, 32'h0000_150A, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    chk(32'(pulse_level), 32'h0000_000A);
    phase_align <= 1'h1;
    repeat (3) @(posedge clk_sys);
    chk(32'(pulse_level), 32'h0000_0015);
    phase_align <= 1'h0;
    wr(OFS_GAIN_SRC, 32'h0000_0000, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    chk(32'(pulse_level), 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_DENOM, pd[k], RESP_OKAY);
      wr(OFS_OCTAVE_HALVING_BIT, pf[k], RESP_OKAY);
      rdr(OFS_STATUS, RESP_OKAY);
      p0 = rd[25:16];
      near(32'(p0), 0, 2);
      repeat (1600) @(posedge clk_sys);
      rdr(OFS_STATUS, RESP_OKAY);
      near(32'(10'(rd[25:16] - p0)), ps[k], 2);
    end
    repeat (100) @(posedge clk_sys);
    phase_align <= 1'h1;
    rdr(OFS_STATUS, RESP_OKAY);
    near(32'(rd[25:16]), 0, 2);
    phase_align <= 1'h0;
    wr(OFS_ATTEN, 32'h0000_00F0, RESP_OKAY);
    wr(OFS_DENOM, 32'h0000_0003, RESP_OKAY);
    dens(2048);
    for (int k = 0; k < 7; k++) begin
      wr(OFS_GAIN_SRC, 32'h0000_0010 | dg[k], RESP_OKAY);
      wr(OFS_DC_LEVEL, 32'(dl[k]), RESP_OKAY);
      dens(de[k]);
    end
    wr(OFS_GAIN_SRC, 32'h0000_0020, RESP_OKAY);
    dens(2458);
    power_down_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    chk(32'(positive_output_oe), 32'h0000_0000);
    chk(32'(negative_output_oe), 32'h0000_0000);
    power_down_n <= 1'h1;
    repeat (3) @(posedge clk_sys);
    chk(32'(positive_output_oe), 32'h0000_0001);
    report_and_stop();
  end
endmodule  // test_signal_mode_generator_tb
bind test_signal_mode_generator tsg_chk tsg_chk_i (.clk_sys, .rst_n, .s_axi_awready,
  .s_axi_awvalid, .s_axi_wready, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .power_down_n, .positive_output,
  .positive_output_oe, .negative_output, .negative_output_oe, .pulse_level);
